// ---- src/sci_pkg.sv ----
// sci_pkg: register map, field positions, reset values, timing and carriers
// assumes: 8-bit register data on a 32-bit apb, one word per register
package sci_pkg;

   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_FMT = 6'h0e;
   localparam logic [5:0] IDX_CTL = 6'h0f;
   localparam logic [5:0] IDX_STAT = 6'h10;
   localparam logic [5:0] IDX_DATA = 6'h11;

   // frame_format_control fields
   localparam int FMT_R8 = 7;
   localparam int FMT_T8 = 6;
   localparam int FMT_M = 4;
   localparam int FMT_WAKE = 3;

   // reset values
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic TX_EMPTY_FLAG_RST = 1'b1;
   localparam logic TC_RST = 1'b1;
   localparam logic IDLE_ARM_RST = 1'b1;

   // oversampling: 16 ticks a bit, votes at ticks 8, 9 and 10
   localparam logic [3:0] RT_LAST = 4'hf;
   localparam logic [3:0] RT_S1 = 4'h7;
   localparam logic [3:0] RT_S2 = 4'h8;
   localparam logic [3:0] RT_S3 = 4'h9;

   // frame lengths in bits, start and stop included
   localparam logic [3:0] LEN8 = 4'ha;
   localparam logic [3:0] LEN9 = 4'hb;

   typedef struct packed {
      logic tx_empty_irq_en;
      logic tx_done_irq_en;
      logic rx_full_irq_en;
      logic line_quiet_irq_en;
      logic te;
      logic re;
      logic rx_sleep;
      logic send_break;
   } sci_ctl_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } sci_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } sci_apb_rsp_t;

   function automatic logic [3:0] sci_frame_len(input logic nine);
      sci_frame_len = nine ? LEN9 : LEN8;
   endfunction

endpackage

// ---- src/sci_line_sync.sv ----
// sci_line_sync: three-stage synchroniser with agreement filter
// assumes: d is asynchronous to pclk
`timescale 1ns/1ps
module sci_line_sync (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // line
   input wire logic d,
   output logic q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
         q <= 1'b1;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            q <= s3_q;
         end
      end
   end
endmodule // sci_line_sync

// ---- src/sci_tx.sv ----
// sci_tx: transmit shifter with preamble, break and trailing mark
// assumes: tick is a one-cycle 16x bit-rate enable on pclk
`timescale 1ns/1ps
module sci_tx (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic tick,
   input wire logic en,
   input wire logic nine,
   input wire logic brk,
   // holding register
   input wire logic full,
   input wire logic [8:0] data,
   output logic take,
   output logic done,
   // serial out
   output logic line_o,
   output logic line_oe
);
   import sci_pkg::*;

   logic en_q;
   logic pre_q;
   logic hi_q;
   logic busy_q;
   logic [3:0] div_q;
   logic [3:0] left_q;
   logic [10:0] sh_q;
   logic end_bit;
   logic start;
   logic [3:0] len;

   assign len = sci_frame_len(nine);
   assign end_bit = tick & busy_q & (div_q == RT_LAST) & (left_q == 4'h1);
   // no start in the cycle the enable rises, so the preamble goes first
   assign start = tick & en & en_q & (~busy_q | end_bit);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= 1'b0;
         pre_q <= 1'b0;
      end else begin
         en_q <= en;
         if (en & ~en_q) begin
            pre_q <= 1'b1;
         end else if (start) begin
            pre_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
         hi_q <= 1'b0;
         div_q <= 4'h0;
         left_q <= 4'h0;
         sh_q <= '1;
         take <= 1'b0;
         done <= 1'b0;
      end else begin
         take <= 1'b0;
         done <= end_bit & (~en | ~(pre_q | brk | hi_q | full));
         if (tick & busy_q) begin
            div_q <= div_q + 4'h1;
            if (div_q == RT_LAST) begin
               sh_q <= {1'b1, sh_q[10:1]};
               left_q <= left_q - 4'h1;
               if (left_q == 4'h1) begin
                  busy_q <= 1'b0;
               end
            end
         end
         if (start) begin
            div_q <= 4'h0;
            if (pre_q) begin
               busy_q <= 1'b1;
               sh_q <= '1;
               left_q <= len;
            end else if (brk) begin
               busy_q <= 1'b1;
               sh_q <= '0;
               left_q <= len;
               hi_q <= 1'b1;
            end else if (hi_q) begin
               busy_q <= 1'b1;
               sh_q <= '1;
               left_q <= 4'h1;
               hi_q <= 1'b0;
            end else if (full) begin
               busy_q <= 1'b1;
               sh_q <= nine ? {1'b1, data, 1'b0} : {2'b11, data[7:0], 1'b0};
               left_q <= len;
               take <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_o <= 1'b1;
         line_oe <= 1'b0;
      end else begin
         line_o <= busy_q ? sh_q[0] : 1'b1;
         line_oe <= en | busy_q;
      end
   end
endmodule // sci_tx

// ---- src/sci_top.sv ----
// sci_top: asynchronous serial transmitter/receiver with apb registers
// assumes: oversample_tick comes from an outside divider on pclk at 16x
// the bit rate; serial_in_line is asynchronous; tx pin is tri-stated
//
// Operation
// - framing error without break keeps receiving, artificial start
// - artificial start forces stop one, qualifies start
// - after break, need a real high first
// - data address reads rx, writes tx holding
// - rx transfer sets full flag, lsb first
// - tx holding moves to shifter after frame
// - format bit selects eight or nine data
// - ninth rx and tx bits, reset keeps them
// - wake method: idle line or address bit
// - sleeping receiver sets no flags, keeps old
// - idle wake clears sleep; no set when idle
// - address wake clears sleep, delivers address byte
// - one interrupt from four enabled sources
// - enable drives line, rising enable sends preamble
// - disable finishes current byte, then tri-state
// - re-enable mid-byte: finish, then new preamble
// - receiver off holds all rx flags clear
// - break sends whole frames of zeros
// - at least one mark after break
// - reset clears control, keeps format bits
// - 16x sampling, three-sample vote, noise flag
// - flag clears by status then data access
`timescale 1ns/1ps
module sci_top (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // register bus
   input sci_pkg::sci_apb_req_t apb_req,
   output sci_pkg::sci_apb_rsp_t apb_rsp,
   // bit-rate enable
   input wire logic oversample_tick,
   // serial lines
   input wire logic serial_in_line,
   output logic tx_line_o,
   output logic tx_line_oe,
   // interrupt
   output logic sci_irq
);
   import sci_pkg::*;

   typedef enum logic {RX_IDLE, RX_FRAME} sci_rx_st_t;

   sci_apb_rsp_t rsp_q;
   sci_ctl_t ctl_q;
   sci_rx_st_t rx_st_q;
   logic rx_ninth_bit;
   logic tx_ninth_bit;
   logic m_q;
   logic wake_q;
   logic [7:0] tx_holding_reg;
   logic [7:0] rx_holding_reg;
   logic tx_empty_flag;
   logic tx_done_flag;
   logic rx_full_flag;
   logic idle_q;
   logic ovr_q;
   logic noise_flag;
   logic framing_error_flag;
   logic [7:0] arm_q;
   logic idle_arm_q;
   logic line;
   logic [3:0] rt_q;
   logic [3:0] bit_q;
   logic [1:0] smp_q;
   logic [8:0] sh_q;
   logic stop_q;
   logic wnoise_q;
   logic need_high_q;
   logic art_q;
   logic [7:0] ones_q;
   logic tx_take;
   logic tx_done;

   logic setup;
   logic acc;
   logic wr_fmt;
   logic wr_ctl;
   logic wr_data;
   logic rd_data;
   logic acc_stat;
   logic [7:0] stat;
   logic [3:0] len;
   logic [7:0] idle_thr;
   logic line_idle;
   logic idle_hit;
   logic vote;
   logic dis;
   logic fin;
   logic ferr;
   logic brk_rx;
   logic msb;
   logic deliver;
   logic xfer;
   logic ovr_ev;
   logic wake_clr;

   function automatic logic addr_is(input logic [7:0] a, input logic [5:0] idx);
      addr_is = (a[7:2] == idx) && (a[1:0] == 2'b00);
   endfunction

   assign apb_rsp = rsp_q;

   // bus decode
   assign setup = apb_req.psel & ~apb_req.penable;
   assign acc = apb_req.psel & apb_req.penable & rsp_q.pready;
   assign wr_fmt = acc & apb_req.pwrite & addr_is(apb_req.paddr, IDX_FMT);
   assign wr_ctl = acc & apb_req.pwrite & addr_is(apb_req.paddr, IDX_CTL);
   assign wr_data = acc & apb_req.pwrite & addr_is(apb_req.paddr, IDX_DATA);
   assign rd_data = acc & ~apb_req.pwrite & addr_is(apb_req.paddr, IDX_DATA);
   assign acc_stat = acc & addr_is(apb_req.paddr, IDX_STAT);

   assign stat = {tx_empty_flag, tx_done_flag, rx_full_flag, idle_q,
                  ovr_q, noise_flag, framing_error_flag, 1'b0};

   // one wait-free access phase; read data captured at setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_q <= '0;
      end else begin
         rsp_q.pready <= setup;
         rsp_q.pslverr <= setup & ~(addr_is(apb_req.paddr, IDX_FMT) |
                                    addr_is(apb_req.paddr, IDX_CTL) |
                                    addr_is(apb_req.paddr, IDX_STAT) |
                                    addr_is(apb_req.paddr, IDX_DATA));
         rsp_q.prdata <= '0;
         if (setup & ~apb_req.pwrite) begin
            if (addr_is(apb_req.paddr, IDX_FMT)) begin
               rsp_q.prdata[7:0] <= {rx_ninth_bit, tx_ninth_bit, 1'b0, m_q,
                                     wake_q, 3'b000};
            end else if (addr_is(apb_req.paddr, IDX_CTL)) begin
               rsp_q.prdata[7:0] <= ctl_q;
            end else if (addr_is(apb_req.paddr, IDX_STAT)) begin
               rsp_q.prdata[7:0] <= stat;
            end else if (addr_is(apb_req.paddr, IDX_DATA)) begin
               rsp_q.prdata[7:0] <= rx_holding_reg;
            end
         end
      end
   end

   // format bits survive reset
   always_ff @(posedge pclk) begin
      if (wr_fmt) begin
         tx_ninth_bit <= apb_req.pwdata[FMT_T8];
         m_q <= apb_req.pwdata[FMT_M];
         wake_q <= apb_req.pwdata[FMT_WAKE];
      end
      if (xfer) begin
         rx_ninth_bit <= sh_q[8];
      end
   end

   // control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= CTL_RST;
      end else begin
         if (wr_ctl) begin
            ctl_q <= apb_req.pwdata[7:0];
            ctl_q.rx_sleep <= apb_req.pwdata[1] & (ctl_q.rx_sleep | ~line_idle);
         end
         if (wake_clr) begin
            ctl_q.rx_sleep <= 1'b0;
         end
      end
   end

   // holding registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_holding_reg <= '0;
         rx_holding_reg <= '0;
      end else begin
         if (wr_data) begin
            tx_holding_reg <= apb_req.pwdata[7:0];
         end
         if (xfer) begin
            rx_holding_reg <= sh_q[7:0];
         end
      end
   end

   // status access arms the flags that are set at that moment
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arm_q <= '0;
      end else if (acc_stat) begin
         arm_q <= stat;
      end else if (rd_data) begin
         arm_q[5:1] <= '0;
      end else if (wr_data) begin
         arm_q[7:6] <= '0;
      end
   end

   // transmit flags; a hardware set beats the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_empty_flag <= TX_EMPTY_FLAG_RST;
         tx_done_flag <= TC_RST;
      end else begin
         if (wr_data & arm_q[7]) begin
            tx_empty_flag <= 1'b0;
         end
         if (wr_data & arm_q[6]) begin
            tx_done_flag <= 1'b0;
         end
         if (tx_take) begin
            tx_empty_flag <= 1'b1;
         end
         if (tx_done) begin
            tx_done_flag <= 1'b1;
         end
      end
   end

   // receive flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_full_flag <= 1'b0;
         idle_q <= 1'b0;
         ovr_q <= 1'b0;
         noise_flag <= 1'b0;
         framing_error_flag <= 1'b0;
      end else if (!ctl_q.re) begin
         rx_full_flag <= 1'b0;
         idle_q <= 1'b0;
         ovr_q <= 1'b0;
         noise_flag <= 1'b0;
         framing_error_flag <= 1'b0;
      end else begin
         if (rd_data) begin
            if (arm_q[5]) rx_full_flag <= 1'b0;
            if (arm_q[4]) idle_q <= 1'b0;
            if (arm_q[3]) ovr_q <= 1'b0;
            if (arm_q[2]) noise_flag <= 1'b0;
            if (arm_q[1]) framing_error_flag <= 1'b0;
         end
         if (xfer) begin
            rx_full_flag <= 1'b1;
            noise_flag <= wnoise_q;
            framing_error_flag <= ferr;
         end
         if (ovr_ev) begin
            ovr_q <= 1'b1;
         end
         if (idle_hit & ~ctl_q.rx_sleep & idle_arm_q) begin
            idle_q <= 1'b1;
         end
      end
   end

   // idle flag rearms only after a new byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_arm_q <= IDLE_ARM_RST;
      end else if (xfer) begin
         idle_arm_q <= 1'b1;
      end else if (idle_hit & ~ctl_q.rx_sleep & ctl_q.re) begin
         idle_arm_q <= 1'b0;
      end
   end

   sci_line_sync u_rx_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(serial_in_line),
      .q(line)
   );

   // line-idle detection in oversample ticks
   assign len = sci_frame_len(m_q);
   assign idle_thr = {len, 4'h0};
   assign line_idle = (ones_q == idle_thr);
   assign idle_hit = oversample_tick & line & (ones_q == idle_thr - 8'h01);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ones_q <= '0;
      end else if (oversample_tick) begin
         if (!line) begin
            ones_q <= '0;
         end else if (!line_idle) begin
            ones_q <= ones_q + 8'h01;
         end
      end
   end

   // vote at the third sample
   assign vote = (smp_q[0] & smp_q[1]) | (smp_q[0] & line) | (smp_q[1] & line);
   assign dis = ~((smp_q[0] == smp_q[1]) & (smp_q[1] == line));

   assign fin = oversample_tick & (rx_st_q == RX_FRAME) & (rt_q == RT_LAST) &
                (bit_q == len - 4'h1);
   assign ferr = ~stop_q;
   assign brk_rx = ferr & (m_q ? (sh_q == 9'h000) : (sh_q[7:0] == 8'h00));
   assign msb = m_q ? sh_q[8] : sh_q[7];
   assign deliver = fin & ctl_q.re & (~ctl_q.rx_sleep | (wake_q & msb));
   assign xfer = deliver & ~rx_full_flag;
   assign ovr_ev = deliver & rx_full_flag;
   assign wake_clr = ctl_q.re & ctl_q.rx_sleep &
                     ((fin & wake_q & msb) | (idle_hit & ~wake_q));

   // receive engine, timed by the outside 16x enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_q <= RX_IDLE;
         rt_q <= '0;
         bit_q <= '0;
         smp_q <= '0;
         sh_q <= '0;
         stop_q <= 1'b1;
         wnoise_q <= 1'b0;
         need_high_q <= 1'b0;
         art_q <= 1'b0;
      end else if (!ctl_q.re) begin
         rx_st_q <= RX_IDLE;
         need_high_q <= 1'b0;
         art_q <= 1'b0;
      end else if (oversample_tick) begin
         unique case (rx_st_q)
            RX_IDLE: begin
               if (line) begin
                  need_high_q <= 1'b0;
               end else if (!need_high_q) begin
                  rx_st_q <= RX_FRAME;
                  rt_q <= 4'h1;
                  bit_q <= '0;
                  wnoise_q <= 1'b0;
                  art_q <= 1'b0;
               end
            end
            RX_FRAME: begin
               rt_q <= rt_q + 4'h1;
               if (rt_q == RT_S1) smp_q[0] <= line;
               if (rt_q == RT_S2) smp_q[1] <= line;
               if (rt_q == RT_S3) begin
                  if (bit_q == 4'h0) begin
                     if (vote & ~art_q) begin
                        rx_st_q <= RX_IDLE;
                     end else begin
                        wnoise_q <= dis & ~art_q;
                     end
                  end else if (bit_q == len - 4'h1) begin
                     stop_q <= vote;
                     wnoise_q <= wnoise_q | dis;
                  end else begin
                     sh_q[bit_q - 4'h1] <= vote;
                     wnoise_q <= wnoise_q | dis;
                  end
               end
               if (rt_q == RT_LAST) begin
                  bit_q <= bit_q + 4'h1;
               end
               if (fin) begin
                  if (ferr & ~brk_rx) begin
                     rx_st_q <= RX_FRAME;
                     stop_q <= 1'b1;
                     rt_q <= '0;
                     bit_q <= '0;
                     wnoise_q <= 1'b0;
                     art_q <= 1'b1;
                  end else begin
                     rx_st_q <= RX_IDLE;
                     need_high_q <= brk_rx;
                     art_q <= 1'b0;
                  end
               end
            end
         endcase
      end
   end

   sci_tx u_tx (
      .pclk(pclk),
      .presetn(presetn),
      .tick(oversample_tick),
      .en(ctl_q.te),
      .nine(m_q),
      .brk(ctl_q.send_break),
      .full(~tx_empty_flag),
      .data({tx_ninth_bit, tx_holding_reg}),
      .take(tx_take),
      .done(tx_done),
      .line_o(tx_line_o),
      .line_oe(tx_line_oe)
   );

   // single serial interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sci_irq <= 1'b0;
      end else begin
         sci_irq <= (ctl_q.tx_empty_irq_en & tx_empty_flag) | (ctl_q.tx_done_irq_en & tx_done_flag) |
                    (ctl_q.rx_full_irq_en & (ovr_q | rx_full_flag)) |
                    (ctl_q.line_quiet_irq_en & idle_q);
      end
   end

endmodule // sci_top

// ---- dv/sci_chk.sv ----
// sci_chk: port-level checks of sci_top
// assumes: bound into sci_top; one clock, reset async active low
`timescale 1ns/1ps
module sci_chk (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // register bus
   input sci_pkg::sci_apb_req_t apb_req,
   input sci_pkg::sci_apb_rsp_t apb_rsp,
   // lines and interrupt
   input wire logic oversample_tick,
   input wire logic serial_in_line,
   input wire logic tx_line_o,
   input wire logic tx_line_oe,
   input wire logic sci_irq
);
   import sci_pkg::*;
   logic [7:0] ctl_q;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      apb_req.psel && !apb_req.penable;
   endsequence
   sequence s_access;
      apb_req.psel && apb_req.penable && apb_rsp.pready;
   endsequence
   // shadow of the control register from completed writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= CTL_RST;
      end else if (apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
                   && apb_req.paddr == {IDX_CTL, 2'b00}) begin
         ctl_q <= apb_req.pwdata[7:0];
      end
   end
   a_ready_after_setup: assert property (s_setup |=> s_access)
      else $error("no ready after setup");
   a_ready_in_access: assert property (apb_rsp.pready |-> apb_req.penable &&
      $past(apb_req.psel) && !$past(apb_req.penable)) else $error("stray ready");
   a_read_upper_zero: assert property (s_access ##0 !apb_req.pwrite |->
      apb_rsp.prdata[31:8] == 24'h0) else $error("read upper bits set");
   a_unmapped_err: assert property (s_access |-> apb_rsp.pslverr ==
      !(apb_req.paddr inside {8'h38, 8'h3c, 8'h40, 8'h44})) else $error("slverr wrong");
   a_irq_masked: assert property (ctl_q[7:4] == 4'h0 && $past(ctl_q[7:4]) == 4'h0
      |-> !sci_irq) else $error("irq with all enables clear");
   a_oe_needs_te: assert property ($rose(tx_line_oe) |-> ctl_q[3])
      else $error("pin driven without enable");
   a_oe_stays_off: assert property (!ctl_q[3] && !tx_line_oe |=> !tx_line_oe)
      else $error("pin driven while disabled");
   a_preamble_high: assert property ($rose(tx_line_oe) |-> tx_line_o [*8])
      else $error("preamble not high");
   a_line_on_tick: assert property (tx_line_oe && $past(tx_line_oe) &&
      $changed(tx_line_o) |-> $past(oversample_tick, 2)) else $error("tx edge off tick");
endmodule // sci_chk

bind sci_top sci_chk i_sci_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .oversample_tick(oversample_tick), .serial_in_line(serial_in_line),
   .tx_line_o(tx_line_o), .tx_line_oe(tx_line_oe), .sci_irq(sci_irq));

// ---- dv/sci_remote.sv ----
// sci_remote: far serial station, sends frames and decodes the tx pin
// assumes: one bit lasts BIT pclk cycles; tx pin has a pull-up
`timescale 1ns/1ps
module sci_remote #(
   parameter int BIT = 32
) (
   // clock
   input wire logic pclk,
   // lines
   output logic rx_line,
   input wire logic tx_pin
);
   initial rx_line = 1'b1;
   // start, data lsb first, stop, then gap idle bits
   task automatic send(input logic [8:0] dat, input logic nine, input logic stop,
                       input int gap);
      logic [10:0] fr;
      fr = nine ? {stop, dat, 1'b0} : {1'b1, stop, dat[7:0], 1'b0};
      for (int i = 0; i < (nine ? 11 : 10); i++) begin
         rx_line <= fr[i];
         repeat (BIT) @(posedge pclk);
      end
      if (gap > 0) begin
         rx_line <= 1'b1;
         repeat (gap * BIT) @(posedge pclk);
      end
   endtask
   task automatic recv(input logic nine, output logic [8:0] dat);
      dat = 9'h0;
      while (tx_pin !== 1'b0) @(posedge pclk);
      repeat (BIT / 2) @(posedge pclk);
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
         repeat (BIT) @(posedge pclk);
         dat[i] = tx_pin;
      end
      repeat (BIT) @(posedge pclk);
   endtask
   // cycles of the next low stretch on the tx pin
   task automatic low_len(output int n);
      n = 0;
      while (tx_pin !== 1'b0) @(posedge pclk);
      while (tx_pin === 1'b0) begin
         @(posedge pclk);
         n++;
      end
   endtask
endmodule // sci_remote

// ---- dv/sci_top_tb.sv ----
// sci_top_tb: scenario bench for sci_top against a remote station
// assumes: tick every second pclk, so one bit is 32 pclk cycles
`timescale 1ns/1ps
module sci_top_tb;
   import sci_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic tick = 1'b0;
   sci_apb_req_t req = '0;
   sci_apb_rsp_t rsp;
   logic rx_line, tx_o, tx_oe, irq, tx_pin, err;
   logic [31:0] d;
   logic [8:0] f;
   int failures = 0;
   int n_compared = 0;
   int cyc = 0;
   int n;
   always #10 pclk = ~pclk;
   always @(posedge pclk) tick <= ~tick;
   // pull-up on the released pin
   assign tx_pin = tx_oe ? tx_o : 1'b1;
   sci_top i_sci_top (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .oversample_tick(tick), .serial_in_line(rx_line), .tx_line_o(tx_o),
      .tx_line_oe(tx_oe), .sci_irq(irq));
   sci_remote i_sci_remote (.pclk(pclk), .rx_line(rx_line), .tx_pin(tx_pin));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
      req <= '{1'b1, 1'b0, wr, {idx, 2'b00}, {24'h0, wd}};
      @(posedge pclk);
      req.penable <= 1'b1;
      @(posedge pclk);
      // only the bench timeout ends this wait
      while (rsp.pready !== 1'b1) begin
         @(posedge pclk);
      end
      d = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
      @(posedge pclk);
   endtask
   task automatic rx_get(input logic [7:0] st, input logic [7:0] dat);
      apb(1'b0, IDX_STAT, 8'h0);
      chk(d & 32'h2a, {24'h0, st});
      apb(1'b0, IDX_DATA, 8'h0);
      chk(d, {24'h0, dat});
   endtask
   task automatic t_reset;
      apb(1'b0, IDX_CTL, 8'h0);
      chk(d, 32'h0);
      apb(1'b0, IDX_STAT, 8'h0);
      chk(d, 32'hc0);
      apb(1'b0, 6'h20, 8'h0);
      chk({31'h0, err}, 32'h1);
   endtask
   task automatic t_tx;
      apb(1'b1, IDX_FMT, 8'h00);
      apb(1'b1, IDX_CTL, 8'h08);
      fork
         i_sci_remote.recv(1'b0, f);
         begin
            apb(1'b0, IDX_STAT, 8'h0);
            apb(1'b1, IDX_DATA, 8'ha5);
            repeat (400) @(posedge pclk);
            apb(1'b1, IDX_CTL, 8'h00);
         end
      join
      chk({23'h0, f}, 32'ha5);
      repeat (40) @(posedge pclk);
      chk({31'h0, tx_oe}, 32'h0);
      apb(1'b1, IDX_FMT, 8'h50);
      apb(1'b1, IDX_CTL, 8'h08);
      fork
         i_sci_remote.recv(1'b1, f);
         begin
            apb(1'b0, IDX_STAT, 8'h0);
            apb(1'b1, IDX_DATA, 8'h3c);
         end
      join
      chk({23'h0, f}, 32'h13c);
   endtask
   task automatic t_rx;
      apb(1'b1, IDX_FMT, 8'h00);
      apb(1'b1, IDX_CTL, 8'h24);
      i_sci_remote.send(9'h096, 1'b0, 1'b1, 1);
      chk({31'h0, irq}, 32'h1);
      rx_get(8'h20, 8'h96);
      apb(1'b0, IDX_STAT, 8'h0);
      chk(d & 32'h20, 32'h0);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, IDX_FMT, 8'h10);
      i_sci_remote.send(9'h15a, 1'b1, 1'b1, 1);
      rx_get(8'h20, 8'h5a);
      apb(1'b0, IDX_FMT, 8'h0);
      chk(d & 32'h80, 32'h80);
   endtask
   task automatic t_wake;
      apb(1'b1, IDX_FMT, 8'h08);
      fork
         i_sci_remote.send(9'h012, 1'b0, 1'b1, 1);
         begin
            repeat (40) @(posedge pclk);
            apb(1'b1, IDX_CTL, 8'h06);
         end
      join
      apb(1'b0, IDX_STAT, 8'h0);
      chk(d & 32'h20, 32'h0);
      i_sci_remote.send(9'h085, 1'b0, 1'b1, 1);
      apb(1'b0, IDX_CTL, 8'h0);
      chk(d, 32'h04);
      rx_get(8'h20, 8'h85);
   endtask
   task automatic t_frame;
      apb(1'b1, IDX_FMT, 8'h00);
      apb(1'b1, IDX_CTL, 8'h04);
      fork
         begin
            i_sci_remote.send(9'h055, 1'b0, 1'b0, 0);
            i_sci_remote.send(9'h033, 1'b0, 1'b1, 1);
         end
         begin
            repeat (345) @(posedge pclk);
            rx_get(8'h22, 8'h55);
         end
      join
      rx_get(8'h20, 8'h33);
      i_sci_remote.send(9'h000, 1'b0, 1'b0, 1);
      rx_get(8'h22, 8'h00);
      i_sci_remote.send(9'h03c, 1'b0, 1'b1, 1);
      rx_get(8'h20, 8'h3c);
   endtask
   task automatic t_break;
      int k;
      k = 0;
      apb(1'b1, IDX_CTL, 8'h0c);
      repeat (400) @(posedge pclk);
      // line idle: a sleep request must not stick
      apb(1'b1, IDX_CTL, 8'h0e);
      apb(1'b0, IDX_CTL, 8'h0);
      chk(d, 32'h0c);
      fork
         i_sci_remote.low_len(n);
         begin
            apb(1'b1, IDX_CTL, 8'h09);
            while (tx_pin !== 1'b0 && k < 1000) begin
               k++;
               @(posedge pclk);
            end
            apb(1'b1, IDX_CTL, 8'h08);
         end
      join
      chk(n, 32'd320);
      repeat (31) @(posedge pclk);
      chk({31'h0, tx_pin}, 32'h1);
   endtask
   task automatic summarize;
      if (failures == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         summarize();
      end
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_tx();
      t_rx();
      t_wake();
      t_frame();
      t_break();
      summarize();
   end
endmodule // sci_top_tb
